// ==== acat_pkg.sv ====
package acat_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets on the plain register port
    localparam logic [7:0] OFS_AUX_CLR   = 8'h36;
    localparam logic [7:0] OFS_AUX_SET   = 8'h37;
    localparam logic [7:0] OFS_CMP_OV    = 8'h38;
    localparam logic [7:0] OFS_CMP_UV    = 8'h39;
    localparam logic [7:0] OFS_ALERT     = 8'h50;
    localparam logic [7:0] OFS_LAST_AUX  = 8'h51;
    localparam logic [7:0] OFS_LAST_CELL = 8'h52;

    // field widths and positions inside the 16-bit word
    localparam int AUX_W   = 14;
    localparam int CMP_W   = 10;
    localparam int AUX_LSB = 2;
    localparam int CMP_LSB = 6;

    // values after reset
    localparam logic [13:0] RST_AUX_CLR = 14'h0000;
    localparam logic [13:0] RST_AUX_SET = 14'h0000;
    localparam logic [9:0]  RST_CMP_OV  = 10'h3ff;
    localparam logic [9:0]  RST_CMP_UV  = 10'h000;
    localparam logic [15:0] RST_WORD    = 16'h0000;

    // boundary codes that switch a check off
    localparam logic [13:0] AUX_SET_OFF = 14'h0000;
    localparam logic [9:0]  CMP_OV_OFF  = 10'h3ff;
    localparam logic [9:0]  CMP_UV_OFF  = 10'h000;

    // reference select code for absolute auxiliary readings
    localparam logic REF_ABSOLUTE = 1'b1;

    // alert register bit positions
    localparam int ALERT_AUX_LOW  = 0;
    localparam int ALERT_CMP_HIGH = 1;
    localparam int ALERT_CMP_LOW  = 2;

    // threshold bank contents
    typedef struct packed {
        logic [13:0] aux_clr;
        logic [13:0] aux_set;
        logic [9:0]  cmp_ov;
        logic [9:0]  cmp_uv;
    } acat_thr_t;

    localparam acat_thr_t RST_THR = '{
        aux_clr: RST_AUX_CLR,
        aux_set: RST_AUX_SET,
        cmp_ov:  RST_CMP_OV,
        cmp_uv:  RST_CMP_UV
    };

endpackage : acat_pkg

// ==== acat_cfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// carries register writes into the bank and thresholds out of it
interface acat_cfg_if;
    import acat_pkg::*;

    logic               wr_en;
    logic [ADDR_W-1:0]  wr_addr;
    logic [DATA_W-1:0]  wr_data;
    acat_thr_t          thr;

    modport bank  (input wr_en, input wr_addr, input wr_data, output thr);
    modport user  (output wr_en, output wr_addr, output wr_data, input thr);
    modport check (input thr);

endinterface : acat_cfg_if

`default_nettype wire

// ==== acat_thr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

module acat_thr_bank
(
    input  wire logic   clk_sys,
    input  wire logic   arst_n,
    acat_cfg_if.bank    cfg
);
    import acat_pkg::*;

    typedef struct packed {
        acat_thr_t thr;
    } acat_bank_state_t;

    acat_bank_state_t st_reg;
    acat_bank_state_t st_next;

    // only the documented field bits are stored; the low bits read zero
    always_comb
    begin
        st_next = st_reg;
        if (cfg.wr_en)
        begin
            unique case (cfg.wr_addr)
                OFS_AUX_CLR:
                    st_next.thr.aux_clr = cfg.wr_data[DATA_W-1:AUX_LSB];
                OFS_AUX_SET:
                    st_next.thr.aux_set = cfg.wr_data[DATA_W-1:AUX_LSB];
                OFS_CMP_OV:
                    st_next.thr.cmp_ov = cfg.wr_data[DATA_W-1:CMP_LSB];
                OFS_CMP_UV:
                    st_next.thr.cmp_uv = cfg.wr_data[DATA_W-1:CMP_LSB];
                default:
                    st_next = st_reg;
            endcase
        end
    end

    // threshold storage
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '{thr: RST_THR};
        else
            st_reg <= st_next;
    end

    assign cfg.thr = st_reg.thr;

endmodule : acat_thr_bank

`default_nettype wire

// ==== acat_level_check.sv ====
`timescale 1ns/1ps
`default_nettype none

module acat_level_check
(
    acat_cfg_if.check          cfg,
    input  wire logic [13:0]   aux_data,
    input  wire logic [9:0]    cell_data,
    output logic               aux_below_trip,
    output logic               aux_at_release,
    output logic               cell_above_high,
    output logic               cell_below_low
);
    import acat_pkg::*;

    // auxiliary hysteresis compares; a zero trip level never trips
    always_comb
    begin
        aux_below_trip = (aux_data < cfg.thr.aux_set);
        aux_at_release = (aux_data >= cfg.thr.aux_clr);
    end

    // comparator window; the boundary codes also gate the compare explicitly
    always_comb
    begin
        cell_above_high = (cfg.thr.cmp_ov != CMP_OV_OFF)
                       && (cell_data > cfg.thr.cmp_ov);
        cell_below_low  = (cfg.thr.cmp_uv != CMP_UV_OFF)
                       && (cell_data < cfg.thr.cmp_uv);
    end

endmodule : acat_level_check

`default_nettype wire

// ==== acat_alert_thresholds.sv ====
// Summary of operation
// - A 14-bit absolute aux release level in bits 15:2 drops the aux low alert at or above it.
// - A 14-bit absolute aux trip level raises the aux low alert for absolute readings below it.
// - A trip level of zero can never be undercut, so absolute aux low checking is off.
// - A 10-bit cell high level in bits 15:6 over 5V flags comparator readings above it.
// - A cell high level of all ones switches comparator high checking off.
// - A 10-bit cell low level in bits 15:6 over 5V flags comparator readings below it.
// - A cell low level of zero switches comparator low checking off.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module acat_alert_thresholds
(
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic [acat_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [acat_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [acat_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                          aux_sample_valid,
    input  wire logic [acat_pkg::AUX_W-1:0]    aux_sample_data,
    input  wire logic                          aux_reference_select,
    input  wire logic                          cell_scan_valid,
    input  wire logic [acat_pkg::CMP_W-1:0]    cell_scan_data,
    output logic                               aux_low_alert_flag,
    output logic                               redundant_high_alert_flag,
    output logic                               redundant_low_alert_flag
);
    import acat_pkg::*;

    // all state of the top level
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              aux_low;
        logic              cell_high;
        logic              cell_low;
        logic [AUX_W-1:0]  last_aux;
        logic [CMP_W-1:0]  last_cell;
    } acat_top_state_t;

    acat_top_state_t st_reg;
    acat_top_state_t st_next;

    acat_cfg_if cfg_bus ();

    logic aux_below_trip;
    logic aux_at_release;
    logic cell_above_high;
    logic cell_below_low;
    logic aux_abs_sample;
    logic alert_wr;
    logic clr_cell_high;
    logic clr_cell_low;
    logic [DATA_W-1:0] rd_word;

    // register writes pass straight to the bank
    assign cfg_bus.wr_en   = reg_wr;
    assign cfg_bus.wr_addr = reg_addr;
    assign cfg_bus.wr_data = reg_wdata;

    // threshold storage
    acat_thr_bank u_bank
    (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .cfg     (cfg_bus)
    );

    // level compares against the stored thresholds
    acat_level_check u_check
    (
        .cfg             (cfg_bus),
        .aux_data        (aux_sample_data),
        .cell_data       (cell_scan_data),
        .aux_below_trip  (aux_below_trip),
        .aux_at_release  (aux_at_release),
        .cell_above_high (cell_above_high),
        .cell_below_low  (cell_below_low)
    );

    // only absolute-reference aux readings are judged here;
    // ratiometric readings belong to another threshold pair
    assign aux_abs_sample = aux_sample_valid
                         && (aux_reference_select == REF_ABSOLUTE);

    // write-one-to-clear decode for the comparator flags
    assign alert_wr      = reg_wr && (reg_addr == OFS_ALERT);
    assign clr_cell_high = alert_wr && reg_wdata[ALERT_CMP_HIGH];
    assign clr_cell_low  = alert_wr && reg_wdata[ALERT_CMP_LOW];

    // read multiplexer; unmapped addresses read zero
    always_comb
    begin
        rd_word = RST_WORD;
        unique case (reg_addr)
            OFS_AUX_CLR:
                rd_word[DATA_W-1:AUX_LSB] = cfg_bus.thr.aux_clr;
            OFS_AUX_SET:
                rd_word[DATA_W-1:AUX_LSB] = cfg_bus.thr.aux_set;
            OFS_CMP_OV:
                rd_word[DATA_W-1:CMP_LSB] = cfg_bus.thr.cmp_ov;
            OFS_CMP_UV:
                rd_word[DATA_W-1:CMP_LSB] = cfg_bus.thr.cmp_uv;
            OFS_ALERT:
            begin
                rd_word[ALERT_AUX_LOW]  = st_reg.aux_low;
                rd_word[ALERT_CMP_HIGH] = st_reg.cell_high;
                rd_word[ALERT_CMP_LOW]  = st_reg.cell_low;
            end
            OFS_LAST_AUX:
                rd_word[DATA_W-1:AUX_LSB] = st_reg.last_aux;
            OFS_LAST_CELL:
                rd_word[DATA_W-1:CMP_LSB] = st_reg.last_cell;
            default:
                rd_word = RST_WORD;
        endcase
    end

    // next-state logic for read data, alerts and sample capture
    always_comb
    begin
        st_next = st_reg;

        // read data stand for the one cycle after the strobe only
        st_next.rdata = reg_rd ? rd_word : RST_WORD;

        // last absolute aux reading, for software inspection
        if (aux_abs_sample)
        begin
            st_next.last_aux = aux_sample_data;
        end

        // last comparator cell reading
        if (cell_scan_valid)
        begin
            st_next.last_cell = cell_scan_data;
        end

        // hysteretic aux low alert; a reading between the two levels keeps
        // the flag as it is, and tripping is checked first so that a
        // misordered pair of levels still reports the low reading
        if (aux_abs_sample)
        begin
            if (aux_below_trip)
            begin
                st_next.aux_low = 1'b1;
            end
            else if (aux_at_release)
            begin
                st_next.aux_low = 1'b0;
            end
        end

        // comparator flags are sticky; software clears by writing one,
        // and a scan that hits in the same cycle wins over the clear
        if (clr_cell_high)
        begin
            st_next.cell_high = 1'b0;
        end
        if (clr_cell_low)
        begin
            st_next.cell_low = 1'b0;
        end
        if (cell_scan_valid)
        begin
            if (cell_above_high)
            begin
                st_next.cell_high = 1'b1;
            end
            if (cell_below_low)
            begin
                st_next.cell_low = 1'b1;
            end
        end
    end

    // single state register of the top level
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '{
                rdata:     RST_WORD,
                aux_low:   1'b0,
                cell_high: 1'b0,
                cell_low:  1'b0,
                last_aux:  RST_AUX_SET,
                last_cell: RST_CMP_UV
            };
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign reg_rdata                 = st_reg.rdata;
    assign aux_low_alert_flag        = st_reg.aux_low;
    assign redundant_high_alert_flag = st_reg.cell_high;
    assign redundant_low_alert_flag  = st_reg.cell_low;

endmodule : acat_alert_thresholds

`default_nettype wire

// ==== acat_alert_thresholds_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module acat_alert_thresholds_chk
(
    input wire logic                        clk_sys,
    input wire logic                        arst_n,
    input wire logic [acat_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [acat_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [acat_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                        aux_sample_valid,
    input wire logic [acat_pkg::AUX_W-1:0]  aux_sample_data,
    input wire logic                        aux_reference_select,
    input wire logic                        cell_scan_valid,
    input wire logic [acat_pkg::CMP_W-1:0]  cell_scan_data,
    input wire logic                        aux_low_alert_flag,
    input wire logic                        redundant_high_alert_flag,
    input wire logic                        redundant_low_alert_flag
);
    import acat_pkg::*;
    logic [13:0] clr_q;
    logic [13:0] set_q;
    logic [9:0]  ov_q;
    logic [9:0]  uv_q;
    logic        aq;

    // only absolute-reference readings count
    assign aq = aux_sample_valid && aux_reference_select == REF_ABSOLUTE;

    // shadow of the levels, updated on the same edge as the bank
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clr_q <= RST_AUX_CLR;
            set_q <= RST_AUX_SET;
            ov_q  <= RST_CMP_OV;
            uv_q  <= RST_CMP_UV;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_AUX_CLR) clr_q <= reg_wdata[15:2];
            if (reg_addr == OFS_AUX_SET) set_q <= reg_wdata[15:2];
            if (reg_addr == OFS_CMP_OV) ov_q <= reg_wdata[15:6];
            if (reg_addr == OFS_CMP_UV) uv_q <= reg_wdata[15:6];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_rel; aq && aux_sample_data >= clr_q && aux_sample_data >= set_q
        |=> !aux_low_alert_flag; endproperty
    a_rel: assert property (p_rel) else $error("aux alert not released");
    property p_trip; aq && aux_sample_data < set_q |=> aux_low_alert_flag; endproperty
    a_trip: assert property (p_trip) else $error("aux alert not raised");
    property p_aoff; set_q == AUX_SET_OFF && !aux_low_alert_flag |=> !aux_low_alert_flag;
    endproperty
    a_aoff: assert property (p_aoff) else $error("aux alert while disabled");
    property p_hi; cell_scan_valid && cell_scan_data > ov_q && ov_q != CMP_OV_OFF
        |=> redundant_high_alert_flag; endproperty
    a_hi: assert property (p_hi) else $error("cell high alert missed");
    property p_hoff; ov_q == CMP_OV_OFF && !redundant_high_alert_flag
        |=> !redundant_high_alert_flag; endproperty
    a_hoff: assert property (p_hoff) else $error("cell high alert while disabled");
    property p_lo; cell_scan_valid && cell_scan_data < uv_q |=> redundant_low_alert_flag;
    endproperty
    a_lo: assert property (p_lo) else $error("cell low alert missed");
    property p_loff; uv_q == CMP_UV_OFF && !redundant_low_alert_flag
        |=> !redundant_low_alert_flag; endproperty
    a_loff: assert property (p_loff) else $error("cell low alert while disabled");
    property p_hold; !aq || (aux_sample_data >= set_q && aux_sample_data < clr_q)
        |=> $stable(aux_low_alert_flag); endproperty
    a_hold: assert property (p_hold) else $error("aux alert moved in band");
    property p_rdclr; reg_rd && reg_addr == OFS_AUX_CLR |=> reg_rdata == {clr_q, 2'h0};
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("release level readback wrong");

    c_trip: cover property (aq && aux_sample_data < set_q);
    c_hi: cover property (cell_scan_valid && cell_scan_data > ov_q && ov_q != CMP_OV_OFF);
    c_lo: cover property (cell_scan_valid && cell_scan_data < uv_q);
endmodule : acat_alert_thresholds_chk

bind acat_alert_thresholds acat_alert_thresholds_chk i_chk (.clk_sys, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .aux_sample_valid, .aux_sample_data,
    .aux_reference_select, .cell_scan_valid, .cell_scan_data, .aux_low_alert_flag,
    .redundant_high_alert_flag, .redundant_low_alert_flag);

`default_nettype wire

// ==== acat_alert_thresholds_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module acat_alert_thresholds_tb;
    import acat_pkg::*;
    logic        clk_sys, arst_n, reg_wr, reg_rd, aux_sample_valid;
    logic        aux_reference_select, cell_scan_valid, aux_low_alert_flag;
    logic        redundant_high_alert_flag, redundant_low_alert_flag;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rnd, d;
    logic [13:0] aux_sample_data, m_clr, m_set, m_la;
    logic [9:0]  cell_scan_data, m_ov, m_uv, m_lc;
    logic        m_aux, m_hi, m_lo;
    int          mismatches, tests_run;

    acat_alert_thresholds i_dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .aux_sample_valid, .aux_sample_data, .aux_reference_select,
        .cell_scan_valid, .cell_scan_data, .aux_low_alert_flag, .redundant_high_alert_flag,
        .redundant_low_alert_flag);

    // 25 MHz system clock
    initial
    begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    function logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lf

    // set wins over release, so a misprogrammed pair still trips
    function logic aux_f(input logic o, input logic [13:0] v);
        if (v < m_set) return 1'h1;
        if (v >= m_clr) return 1'h0;
        return o;
    endfunction : aux_f

    function logic [15:0] rexp(input logic [7:0] a);
        case (a)
            OFS_AUX_CLR: return {m_clr, 2'h0};
            OFS_AUX_SET: return {m_set, 2'h0};
            OFS_CMP_OV:  return {m_ov, 6'h0};
            OFS_CMP_UV:  return {m_uv, 6'h0};
            OFS_ALERT:   return {13'h0, m_lo, m_hi, m_aux};
            OFS_LAST_AUX:  return {m_la, 2'h0};
            OFS_LAST_CELL: return {m_lc, 6'h0};
            default:     return 16'h0;
        endcase
    endfunction : rexp

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, exp, seen);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        case (a)
            OFS_AUX_CLR: m_clr = v[15:2];
            OFS_AUX_SET: m_set = v[15:2];
            OFS_CMP_OV:  m_ov = v[15:6];
            OFS_CMP_UV:  m_uv = v[15:6];
            default: ;
        endcase
        if (a == OFS_ALERT && v[1]) m_hi = 1'h0;
        if (a == OFS_ALERT && v[2]) m_lo = 1'h0;
    endtask : wr

    // read data stand one cycle only, then return to zero
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 chk("rdata", reg_rdata, rexp(a));
        @(posedge clk_sys);
        #1 chk("rdata idle", reg_rdata, 16'h0);
    endtask : rd

    task smp(input logic v, input logic rf, input logic [13:0] ad, input logic cv,
             input logic [9:0] cd);
        @(posedge clk_sys);
        aux_sample_valid     <= v;
        aux_reference_select <= rf;
        aux_sample_data      <= ad;
        cell_scan_valid      <= cv;
        cell_scan_data       <= cd;
        @(posedge clk_sys);
        aux_sample_valid <= 1'h0;
        cell_scan_valid  <= 1'h0;
        if (v && rf) m_aux = aux_f(m_aux, ad);
        if (cv) m_hi = m_hi | (cd > m_ov && m_ov != CMP_OV_OFF);
        if (cv) m_lo = m_lo | (cd < m_uv);
        if (v && rf) m_la = ad;
        if (cv) m_lc = cd;
        #1 chk("flags", {13'h0, redundant_low_alert_flag, redundant_high_alert_flag,
            aux_low_alert_flag}, {13'h0, m_lo, m_hi, m_aux});
    endtask : smp

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // whole run needs about 900 cycles; allow ten thousand
    initial
    begin
        #400000;
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        {arst_n, reg_wr, reg_rd, aux_sample_valid, cell_scan_valid} = 5'h0;
        {aux_reference_select, m_aux, m_hi, m_lo} = 4'h0;
        {reg_addr, reg_wdata, aux_sample_data, cell_scan_data} = 48'h0;
        {m_clr, m_set, m_ov, m_uv} = {RST_AUX_CLR, RST_AUX_SET, RST_CMP_OV, RST_CMP_UV};
        {mismatches, tests_run} = 64'h0;
        {m_la, m_lc} = 24'h0;
        rnd = 16'h0009;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'h1;
        rd(OFS_AUX_CLR);
        rd(OFS_AUX_SET);
        rd(OFS_CMP_OV);
        rd(OFS_CMP_UV);
        rd(8'h40);
        smp(1'h1, 1'h1, 14'h0, 1'h1, 10'h0);
        wr(OFS_AUX_SET, 16'h0403);
        wr(OFS_AUX_CLR, 16'h0800);
        rd(OFS_AUX_SET);
        smp(1'h1, 1'h0, 14'h0ff, 1'h0, 10'h0);
        rd(OFS_LAST_AUX);
        wr(OFS_LAST_AUX, 16'hffff);
        rd(OFS_LAST_AUX);
        smp(1'h1, 1'h1, 14'h0ff, 1'h0, 10'h0);
        // software cannot clear the aux flag; the next sample shows it held
        wr(OFS_ALERT, 16'h0001);
        smp(1'h1, 1'h1, 14'h1ff, 1'h0, 10'h0);
        smp(1'h1, 1'h1, 14'h100, 1'h0, 10'h0);
        smp(1'h1, 1'h1, 14'h200, 1'h0, 10'h0);
        wr(OFS_CMP_OV, 16'h403f);
        rd(OFS_CMP_OV);
        smp(1'h0, 1'h1, 14'h0, 1'h1, 10'h100);
        smp(1'h0, 1'h1, 14'h0, 1'h1, 10'h101);
        rd(OFS_ALERT);
        rd(OFS_LAST_CELL);
        wr(OFS_ALERT, 16'h0002);
        smp(1'h0, 1'h1, 14'h0, 1'h0, 10'h0);
        wr(OFS_CMP_OV, 16'hffc0);
        smp(1'h0, 1'h1, 14'h0, 1'h1, 10'h3ff);
        wr(OFS_CMP_UV, 16'h1400);
        smp(1'h0, 1'h1, 14'h0, 1'h1, 10'h050);
        smp(1'h0, 1'h1, 14'h0, 1'h1, 10'h04f);
        // a clear that meets a hitting scan in one cycle loses to it
        @(posedge clk_sys);
        reg_wr          <= 1'h1;
        reg_addr        <= OFS_ALERT;
        reg_wdata       <= 16'h0004;
        cell_scan_valid <= 1'h1;
        @(posedge clk_sys);
        reg_wr          <= 1'h0;
        cell_scan_valid <= 1'h0;
        #1 chk("set wins", {15'h0, redundant_low_alert_flag}, 16'h0001);
        wr(OFS_ALERT, 16'h0004);
        wr(OFS_CMP_UV, 16'h0000);
        smp(1'h0, 1'h1, 14'h0, 1'h1, 10'h0);
        // random traffic; levels stay ordered as software is asked to keep them
        repeat (200)
        begin
            rnd = lf(rnd);
            d = rnd;
            if (d[2:0] == 3'h0)
            begin
                wr(OFS_AUX_SET, {2'h0, d[15:4], 2'h0});
                wr(OFS_AUX_CLR, {1'h1, d[14:0]});
                wr(OFS_CMP_OV, {1'h1, d[11:3], 6'h0});
                wr(OFS_CMP_UV, {1'h0, d[12:4], 6'h0});
                wr(OFS_ALERT, 16'h0006);
            end
            rnd = lf(rnd);
            smp(d[15], d[14], rnd[13:0], d[13], rnd[15:6]);
            if (d[5:3] == 3'h0) rd(8'h36 + {6'h0, d[7:6]});
            if (d[5:3] == 3'h1) rd(OFS_ALERT + {6'h0, d[7:6]});
        end
        report_and_stop();
    end
endmodule : acat_alert_thresholds_tb

`default_nettype wire
